/* rtl/adcc_pkg.sv */
// Shared constants and types of the converter control and status block.
package adcc_pkg;
	// Word addresses of the register slots on the Avalon-MM slave.
	localparam logic [2:0] ADDR_SC1 = 3'h0;
	localparam logic [2:0] ADDR_SC2 = 3'h1;
	localparam logic [2:0] ADDR_RES_LO = 3'h2;
	localparam logic [2:0] ADDR_RES_HI = 3'h3;
	localparam logic [2:0] ADDR_CMP_LO = 3'h4;
	localparam logic [2:0] ADDR_CMP_HI = 3'h5;
	localparam logic [2:0] ADDR_IRQ_STS = 3'h6;
	localparam logic [2:0] ADDR_IRQ_MSK = 3'h7;

	// Field positions.
	localparam int SC1_DONE_BIT = 7;
	localparam int SC1_IEN_BIT = 6;
	localparam int SC1_CONT_BIT = 5;
	localparam int SC2_ACT_BIT = 7;
	localparam int SC2_TRG_BIT = 6;
	localparam int SC2_CMPEN_BIT = 5;
	localparam int SC2_CMPGE_BIT = 4;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ABORT_BIT = 1;

	// Channel codes with a special meaning.
	localparam logic [4:0] CH_RESERVED = 5'h1c;
	localparam logic [4:0] CH_REF_HIGH = 5'h1d;
	localparam logic [4:0] CH_REF_LOW = 5'h1e;
	localparam logic [4:0] CH_DISABLED = 5'h1f;

	// Values after reset.
	localparam logic [4:0] CH_RST = 5'h1f;
	localparam logic [11:0] CMP_RST = 12'h000;
	localparam logic [1:0] IRQ_MSK_RST = 2'h1;
	localparam logic [11:0] RES_RST = 12'h000;

	// Conversion time of the converter core, rounded up to whole bus cycles.
	localparam int CLK_PERIOD_NS = 40;
	localparam int CONV_TIME_NS = 1000;
	localparam int CONV_CYCLES_INT = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] CONV_LAST = 6'(CONV_CYCLES_INT - 1);

	typedef enum logic {ST_IDLE, ST_CONV} adcc_state_t;

	typedef struct packed {
		logic ien;
		logic cont;
		logic [4:0] ch;
	} adcc_sc1_t;

	typedef struct packed {
		logic trg;
		logic cmp_en;
		logic cmp_ge;
	} adcc_sc2_t;
endpackage

/* rtl/adcc_trig_sync.sv */
// Hardware trigger synchroniser and rising edge detector.
`timescale 1ns/100ps
module adcc_trig_sync
	import adcc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic trig_in,
	output logic trig_pulse
);
	logic meta_ff;
	logic sync_ff;
	logic last_ff;
	logic pulse_ff;

	// The first stage feeds only the second stage.
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end
		else
		begin
			meta_ff <= trig_in;
			sync_ff <= meta_ff;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			last_ff <= 1'b0;
			pulse_ff <= 1'b0;
		end
		else
		begin
			last_ff <= sync_ff;
			pulse_ff <= sync_ff && !last_ff;
		end
	end

	assign trig_pulse = pulse_ff;

	one_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
		pulse_ff |=> !pulse_ff)
		else $error("trigger pulse lasted more than one cycle");
endmodule

/* rtl/adcc_ctrl.sv */
// Control and status logic of a successive approximation converter with an Avalon-MM slave.
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// - Writing first register aborts, restarts in software trigger mode unless disabled
// - Compare off: every finish sets done flag
// - Compare on: done flag only on true
// - Done flag clears on first-register write, low-result read
// - Done flag with enable raises the interrupt
// - Continuous off: one conversion per start event
// - Continuous on: converts repeatedly once started
// - Channel field decodes inputs, references, disable
// - All-ones channel powers down, stops, no extra
// - Single mode drops to low power after conversion
// - Active flag set at start, cleared end/abort
// - Trigger select picks software or hardware start
// - Second register bit 5 enables compare
// - Direction bit: less-than or greater-equal
// - Failed compare leaves result registers unchanged
module adcc_ctrl
	import adcc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic hardware_trigger_input,
	input wire logic [11:0] conv_data,
	output logic [4:0] channel_select,
	output logic conv_power,
	output logic input_isolate,
	output logic ref_select,
	output logic irq
);
	adcc_sc1_t sc1_ff;
	adcc_sc2_t sc2_ff;
	adcc_state_t state_ff;
	adcc_state_t nxt_state;
	logic conversion_done_flag_ff;
	logic [5:0] cnt_ff;
	logic [11:0] result_ff;
	logic [11:0] cmp_ff;
	logic [1:0] irq_sts_ff;
	logic [1:0] irq_msk_ff;
	logic irq_ff;
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [4:0] chan_ff;
	logic power_ff;
	logic isolate_ff;
	logic ref_ff;
	logic trig_pulse;
	logic acc_wr;
	logic acc_rd;
	logic sc1_wr;
	logic res_lo_rd;
	logic [4:0] wr_ch;
	logic start_sw;
	logic start_hw;
	logic done;
	logic restart;
	logic cmp_true;
	logic hit;
	logic set_done;
	logic [1:0] irq_set;

	adcc_trig_sync u_trig (
		.mclk(mclk),
		.rst_b(rst_b),
		.trig_in(hardware_trigger_input),
		.trig_pulse(trig_pulse)
	);

	////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: every access sees exactly one wait cycle.

	assign acc_wr = avs_write && !wait_ff;
	assign acc_rd = avs_read && !wait_ff;
	assign sc1_wr = acc_wr && (avs_address == ADDR_SC1) && avs_byteenable[0];
	assign res_lo_rd = acc_rd && (avs_address == ADDR_RES_LO);
	assign wr_ch = avs_writedata[4:0];

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			wait_ff <= 1'b1;
		else if ((avs_read || avs_write) && wait_ff)
			wait_ff <= 1'b0;
		else
			wait_ff <= 1'b1;
	end

	// Reserved and unmapped bits read as zero.
	always_comb
	begin
		nxt_rdata = 32'h0;
		unique case (avs_address)
			ADDR_SC1: nxt_rdata[7:0] = {conversion_done_flag_ff, sc1_ff.ien, sc1_ff.cont, sc1_ff.ch};
			ADDR_SC2: nxt_rdata[7:0] = {state_ff == ST_CONV, sc2_ff.trg, sc2_ff.cmp_en,
				sc2_ff.cmp_ge, 4'h0};
			ADDR_RES_LO: nxt_rdata[7:0] = result_ff[7:0];
			ADDR_RES_HI: nxt_rdata[3:0] = result_ff[11:8];
			ADDR_CMP_LO: nxt_rdata[7:0] = cmp_ff[7:0];
			ADDR_CMP_HI: nxt_rdata[3:0] = cmp_ff[11:8];
			ADDR_IRQ_STS: nxt_rdata[1:0] = irq_sts_ff;
			ADDR_IRQ_MSK: nxt_rdata[1:0] = irq_msk_ff;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			rdata_ff <= 32'h0;
		else if (avs_read && wait_ff)
			rdata_ff <= nxt_rdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// Control registers.

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			sc1_ff <= '{ien: 1'b0, cont: 1'b0, ch: CH_RST};
		else if (sc1_wr)
			sc1_ff <= '{ien: avs_writedata[SC1_IEN_BIT], cont: avs_writedata[SC1_CONT_BIT],
				ch: wr_ch};
	end

	// The four low bits are reserved and are not stored.
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			sc2_ff <= '{trg: 1'b0, cmp_en: 1'b0, cmp_ge: 1'b0};
		else if (acc_wr && (avs_address == ADDR_SC2) && avs_byteenable[0])
			sc2_ff <= '{trg: avs_writedata[SC2_TRG_BIT], cmp_en: avs_writedata[SC2_CMPEN_BIT],
				cmp_ge: avs_writedata[SC2_CMPGE_BIT]};
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			cmp_ff <= CMP_RST;
		else if (acc_wr && avs_byteenable[0] && (avs_address == ADDR_CMP_LO))
			cmp_ff[7:0] <= avs_writedata[7:0];
		else if (acc_wr && avs_byteenable[0] && (avs_address == ADDR_CMP_HI))
			cmp_ff[11:8] <= avs_writedata[3:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer.

	// In hardware trigger mode a write only aborts; the next trigger edge starts.
	assign start_sw = sc1_wr && (wr_ch != CH_DISABLED) && !sc2_ff.trg;
	assign start_hw = trig_pulse && sc2_ff.trg && (sc1_ff.ch != CH_DISABLED)
		&& (state_ff == ST_IDLE) && !sc1_wr;
	assign done = (state_ff == ST_CONV) && (cnt_ff == CONV_LAST) && !sc1_wr;
	assign restart = done && sc1_ff.cont && (sc1_ff.ch != CH_DISABLED);

	always_comb
	begin
		nxt_state = state_ff;
		if (sc1_wr)
			nxt_state = start_sw ? ST_CONV : ST_IDLE;
		else if (start_hw)
			nxt_state = ST_CONV;
		else if (done)
			nxt_state = restart ? ST_CONV : ST_IDLE;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			cnt_ff <= 6'h0;
		else if (start_sw || start_hw || restart)
			cnt_ff <= 6'h0;
		else if (state_ff == ST_CONV)
			cnt_ff <= cnt_ff + 6'h1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Compare, result and done flag.

	assign cmp_true = sc2_ff.cmp_ge ? (conv_data >= cmp_ff) : (conv_data < cmp_ff);
	assign hit = !sc2_ff.cmp_en || cmp_true;
	assign set_done = done && hit;

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			result_ff <= RES_RST;
		else if (set_done)
			result_ff <= conv_data;
	end

	// A completion in the clearing cycle wins over the clear.
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			conversion_done_flag_ff <= 1'b0;
		else if (set_done)
			conversion_done_flag_ff <= 1'b1;
		else if (sc1_wr || res_lo_rd)
			conversion_done_flag_ff <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status, mask and output.

	assign irq_set[IRQ_DONE_BIT] = set_done && sc1_ff.ien;
	assign irq_set[IRQ_ABORT_BIT] = sc1_wr && (state_ff == ST_CONV);

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			irq_sts_ff <= 2'h0;
		else if (acc_wr && avs_byteenable[0] && (avs_address == ADDR_IRQ_STS))
			irq_sts_ff <= irq_set | (irq_sts_ff & ~avs_writedata[1:0]);
		else
			irq_sts_ff <= irq_sts_ff | irq_set;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			irq_msk_ff <= IRQ_MSK_RST;
		else if (acc_wr && avs_byteenable[0] && (avs_address == ADDR_IRQ_MSK))
			irq_msk_ff <= avs_writedata[1:0];
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(irq_sts_ff & irq_msk_ff);
	end

	////////////////////////////////////////////////////////////////////////////
	// Converter front-end controls.

	// Power follows the sequencer, so single conversions fall back to low power.
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			chan_ff <= CH_RST;
			power_ff <= 1'b0;
			isolate_ff <= 1'b1;
			ref_ff <= 1'b0;
		end
		else
		begin
			chan_ff <= sc1_ff.ch;
			power_ff <= (nxt_state == ST_CONV);
			isolate_ff <= (sc1_ff.ch == CH_DISABLED) || (sc1_ff.ch == CH_RESERVED);
			ref_ff <= (sc1_ff.ch == CH_REF_HIGH) || (sc1_ff.ch == CH_REF_LOW);
		end
	end

	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign channel_select = chan_ff;
	assign conv_power = power_ff;
	assign input_isolate = isolate_ff;
	assign ref_select = ref_ff;
	assign irq = irq_ff;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking dcb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	sequence seq_begin;
		state_ff == ST_CONV && cnt_ff == 6'h0;
	endsequence

	sequence seq_idle;
		state_ff == ST_IDLE && !power_ff;
	endsequence

	abort_restart_a: assert property (start_sw |=> seq_begin)
		else $error("write did not restart the conversion");
	plain_done_a: assert property (done && !sc2_ff.cmp_en |=> conversion_done_flag_ff)
		else $error("done flag not set with compare off");
	cmp_gate_a: assert property (done && sc2_ff.cmp_en && !cmp_true && !sc1_wr && !res_lo_rd
		|=> conversion_done_flag_ff == $past(conversion_done_flag_ff))
		else $error("done flag changed on failed compare");
	flag_clear_a: assert property ((sc1_wr || res_lo_rd) && !set_done
		|=> !conversion_done_flag_ff)
		else $error("done flag not cleared");
	done_irq_a: assert property (set_done && sc1_ff.ien && irq_msk_ff[IRQ_DONE_BIT]
		&& !(acc_wr && avs_address == ADDR_IRQ_STS)
		&& !(acc_wr && avs_address == ADDR_IRQ_MSK) |-> ##2 irq)
		else $error("interrupt not raised after done");
	no_irq_a: assert property (irq_sts_ff == 2'h0 |=> !irq)
		else $error("interrupt without status");
	single_shot_a: assert property (done && !sc1_ff.cont |=> seq_idle)
		else $error("single conversion did not stop");
	repeat_conv_a: assert property (restart
		|=> seq_begin ##1 (state_ff == ST_CONV || $past(sc1_wr)))
		else $error("continuous conversion did not repeat");
	chan_off_a: assert property (sc1_wr && wr_ch == CH_DISABLED
		|=> seq_idle ##1 isolate_ff)
		else $error("disable code did not stop the converter");
	// A register write may abort in the second cycle; that is a legal end of the conversion.
	active_span_a: assert property (start_hw
		|=> state_ff == ST_CONV ##1 (state_ff == ST_CONV || $past(sc1_wr)))
		else $error("active flag not held after start");
	trig_mode_a: assert property (trig_pulse && !sc2_ff.trg && state_ff == ST_IDLE && !sc1_wr
		|=> state_ff == ST_IDLE)
		else $error("trigger started conversion in software mode");
	ge_compare_a: assert property (done && sc2_ff.cmp_en && sc2_ff.cmp_ge
		&& conv_data >= cmp_ff |=> conversion_done_flag_ff)
		else $error("greater-equal compare missed");
	keep_result_a: assert property (done && !hit |=> $stable(result_ff))
		else $error("result changed on failed compare");
endmodule

/* bench/adcc_testbench.sv */
// Self-checking testbench of the converter control and status block.
`timescale 1ns/100ps
module testbench
	import adcc_pkg::*;
;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] avs_address = 3'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h1;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic hardware_trigger_input = 1'b0;
	logic [11:0] conv_data = 12'h000;
	logic [4:0] channel_select;
	logic conv_power;
	logic input_isolate;
	logic ref_select;
	logic irq;
	int mismatches = 0;
	int check_count = 0;
	logic [11:0] res;
	logic [11:0] cd [4] = '{12'h900, 12'h100, 12'h900, 12'h100};
	logic [7:0] sc2v [4] = '{8'h20, 8'h20, 8'h30, 8'h30};
	logic hit [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
	logic [4:0] chv [5] = '{5'h00, 5'h1b, 5'h1c, 5'h1d, 5'h1e};

	adcc_ctrl dut (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.hardware_trigger_input(hardware_trigger_input), .conv_data(conv_data),
		.channel_select(channel_select), .conv_power(conv_power), .input_isolate(input_isolate),
		.ref_select(ref_select), .irq(irq));

	initial
	begin
		forever #20 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// The request rises just after a rising edge and stands until the edge that samples
	// waitrequest low; read data are taken and the request is dropped at that same edge.
	task automatic bus(input logic [2:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		int n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= !w;
		avs_write <= w;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		chk(12'(n < 50), 12'h1);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(a, 1'b1, d, q);
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] q;
		bus(a, 1'b0, 8'h0, q);
		chk(12'(q), 12'(exp));
	endtask

	task automatic pin(input logic got, input logic exp);
		@(negedge mclk);
		chk(12'(got), 12'(exp));
	endtask

	task automatic wait_conv();
		int n = 0;
		repeat (2) @(posedge mclk);
		while (conv_power !== 1'b0 && n < 200)
		begin
			@(negedge mclk);
			n++;
		end
		chk(12'(n < 200), 12'h1);
		repeat (2) @(posedge mclk);
	endtask

	task automatic poll_done();
		logic [7:0] q;
		int n = 0;
		q = 8'h0;
		while (q[7] !== 1'b1 && n < 60)
		begin
			bus(ADDR_SC1, 1'b0, 8'h0, q);
			n++;
		end
		chk(12'(q[7]), 12'h1);
	endtask

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#(40 * 20000);
		mismatches++;
		close_out();
	end

	initial
	begin
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		rd(ADDR_SC1, 8'h1f);
		rd(ADDR_SC2, 8'h00);
		rd(ADDR_IRQ_MSK, 8'h01);
		conv_data <= 12'habc;
		pin(input_isolate, 1'b1);
		// Single software conversion; the block must go idle by itself.
		wr(ADDR_SC1, 8'h05);
		repeat (3) @(posedge mclk);
		rd(ADDR_SC2, 8'h80);
		wait_conv();
		res = 12'habc;
		rd(ADDR_SC1, 8'h85);
		rd(ADDR_SC2, 8'h00);
		rd(ADDR_RES_HI, 8'h0a);
		rd(ADDR_RES_LO, 8'hbc);
		rd(ADDR_SC1, 8'h05);
		repeat (40) @(posedge mclk);
		pin(conv_power, 1'b0);
		// Interrupt: raise, clear, mask.
		wr(ADDR_IRQ_STS, 8'h03);
		wr(ADDR_SC1, 8'h45);
		wait_conv();
		repeat (4) @(posedge mclk);
		pin(irq, 1'b1);
		rd(ADDR_IRQ_STS, 8'h01);
		wr(ADDR_IRQ_STS, 8'h01);
		wr(ADDR_SC1, 8'h45);
		rd(ADDR_SC1, 8'h45);
		pin(irq, 1'b0);
		wr(ADDR_IRQ_MSK, 8'h00);
		wait_conv();
		repeat (4) @(posedge mclk);
		pin(irq, 1'b0);
		wr(ADDR_IRQ_MSK, 8'h01);
		repeat (4) @(posedge mclk);
		pin(irq, 1'b1);
		wr(ADDR_IRQ_STS, 8'h03);
		wr(ADDR_SC1, 8'h05);
		wait_conv();
		repeat (4) @(posedge mclk);
		pin(irq, 1'b0);
		// Abort in mid-conversion by selecting the disabled channel.
		wr(ADDR_IRQ_STS, 8'h03);
		wr(ADDR_SC1, 8'h05);
		repeat (5) @(posedge mclk);
		wr(ADDR_SC1, 8'h1f);
		rd(ADDR_SC2, 8'h00);
		pin(conv_power, 1'b0);
		rd(ADDR_IRQ_STS, 8'h02);
		repeat (40) @(posedge mclk);
		rd(ADDR_SC1, 8'h1f);
		// Continuous conversion, then stopped with no extra conversion.
		conv_data <= 12'h123;
		wr(ADDR_SC1, 8'h25);
		poll_done();
		rd(ADDR_RES_LO, 8'h23);
		poll_done();
		res = 12'h123;
		wr(ADDR_SC1, 8'h1f);
		rd(ADDR_SC2, 8'h00);
		repeat (40) @(posedge mclk);
		rd(ADDR_SC1, 8'h1f);
		// A write without byte 0 enabled is ignored; the register keeps its reset value.
		avs_byteenable <= 4'h0;
		wr(ADDR_SC2, 8'h20);
		avs_byteenable <= 4'h1;
		rd(ADDR_SC2, 8'h00);
		// Automatic compare against 12'h800 in both directions.
		wr(ADDR_CMP_LO, 8'h00);
		wr(ADDR_CMP_HI, 8'h08);
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_SC2, sc2v[i]);
			conv_data <= cd[i];
			wr(ADDR_SC1, 8'h05);
			wait_conv();
			if (hit[i])
				res = cd[i];
			rd(ADDR_SC1, hit[i] ? 8'h85 : 8'h05);
			rd(ADDR_RES_HI, 8'(res[11:8]));
			rd(ADDR_RES_LO, res[7:0]);
		end
		// Hardware trigger: a register write does not start, one edge gives one conversion.
		wr(ADDR_SC2, 8'h40);
		wr(ADDR_SC1, 8'h05);
		repeat (5) @(posedge mclk);
		pin(conv_power, 1'b0);
		@(posedge mclk);
		hardware_trigger_input <= 1'b1;
		repeat (10) @(posedge mclk);
		pin(conv_power, 1'b1);
		wait_conv();
		repeat (40) @(posedge mclk);
		pin(conv_power, 1'b0);
		rd(ADDR_SC1, 8'h85);
		hardware_trigger_input <= 1'b0;
		wr(ADDR_SC2, 8'h00);
		// In software trigger mode a trigger edge must not start a conversion.
		hardware_trigger_input <= 1'b1;
		repeat (10) @(posedge mclk);
		pin(conv_power, 1'b0);
		rd(ADDR_SC2, 8'h00);
		// Channel decode of inputs, reserved code and references.
		for (int i = 0; i < 5; i++)
		begin
			wr(ADDR_SC1, 8'(chv[i]));
			repeat (2) @(negedge mclk);
			pin(channel_select === chv[i], 1'b1);
			pin(ref_select, chv[i] == CH_REF_HIGH || chv[i] == CH_REF_LOW);
			pin(input_isolate, chv[i] == CH_RESERVED);
			wait_conv();
		end
		wr(ADDR_SC1, 8'h1f);
		repeat (2) @(negedge mclk);
		pin(input_isolate, 1'b1);
		pin(ref_select, 1'b0);
		close_out();
	end
endmodule
